// ---- pkg/sfrb_pkg.sv ----
`default_nettype none
package sfrb_pkg;

  // ----------------------------------------
  // File addresses within a bank
  // ----------------------------------------
  localparam logic [6:0] OFF_WINDOW = 7'h00;
  localparam logic [6:0] OFF_TIMER0_COUNT = 7'h01;
  localparam logic [6:0] OFF_PCL = 7'h02;
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_PTR = 7'h04;
  localparam logic [6:0] OFF_FIRST_PORT_DATA = 7'h05;
  localparam logic [6:0] OFF_SECOND_PORT_DATA = 7'h06;
  localparam logic [6:0] OFF_AUX = 7'h07;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_HIGH_LATCH = 7'h0A;
  localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0B;
  localparam logic [6:0] OFF_PIR = 7'h0C;
  localparam logic [6:0] OFF_T1L = 7'h0E;
  localparam logic [6:0] OFF_T1H = 7'h0F;
  localparam logic [6:0] OFF_TIMER1_CONTROL = 7'h10;
  localparam logic [6:0] OFF_TIMER2_COUNT = 7'h11;
  localparam logic [6:0] OFF_TIMER2_CONTROL = 7'h12;
  localparam logic [6:0] OFF_CCPL = 7'h15;
  localparam logic [6:0] OFF_CCPH = 7'h16;
  localparam logic [6:0] OFF_CCPCON = 7'h17;
  localparam logic [6:0] OFF_CONVERTER_RESULT = 7'h1E;
  localparam logic [6:0] OFF_ADCON = 7'h1F;
  // Direction registers, bank one
  localparam logic [6:0] OFF_DIRA = 7'h05;
  localparam logic [6:0] OFF_DIRB = 7'h06;

  // ----------------------------------------
  // Banks and field positions
  // ----------------------------------------
  localparam logic [1:0] BANK_ZERO = 2'h0;
  localparam logic [1:0] BANK_ONE = 2'h1;
  localparam int unsigned STAT_BANK_LO = 5;
  localparam int unsigned STAT_BANK_HI = 6;
  localparam int unsigned STAT_IND_BANK = 7;
  localparam int unsigned PTR_BANK = 7;

  // ----------------------------------------
  // Implemented bit masks
  // ----------------------------------------
  localparam logic [7:0] STATUS_WMASK = 8'hE7;
  localparam logic [7:0] PIR_MASK = 8'h47;
  localparam logic [7:0] TIMER1_CONTROL_MASK = 8'h3F;
  localparam logic [7:0] TIMER2_CONTROL_MASK = 8'h7F;
  localparam logic [7:0] CCPCON_MASK = 8'h3F;
  localparam logic [7:0] ADCON_MASK = 8'hFD;
  localparam logic [7:0] FIRST_PORT_DATA_MASK = 8'h1F;
  localparam logic [7:0] AUX_MASK = 8'h05;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] STATUS_KEEP = 8'h1F;
  localparam logic [7:0] INTERRUPT_CONTROL_KEEP = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------
  // Access targets
  // ----------------------------------------
  typedef enum logic [3:0] {
    K_NONE, K_RAM, K_PCL, K_STAT, K_PTR, K_PROGRAM_COUNTER_HIGH_LATCH, K_INTERRUPT_CONTROL, K_PIR,
    K_TIMER1_CONTROL, K_TIMER2_COUNT, K_TIMER2_CONTROL, K_CCPCON, K_ADCON, K_FIRST_PORT_DATA, K_SECOND_PORT_DATA, K_DIRAB
  } sfrb_kind_t;

  typedef struct packed {
    sfrb_kind_t kind;
    logic [4:0] ram_addr;
    logic port_b;
  } sfrb_target_t;

  typedef struct packed {
    logic [7:0] interrupt_control;
    logic [7:0] timer1_control;
    logic [7:0] timer2_control;
    logic [7:0] timer2_count;
    logic [7:0] ccpcon;
    logic [7:0] adcon;
  } sfrb_ctrl_t;

  function automatic logic sfrb_is_dual(input logic [6:0] fa);
    return (fa == OFF_WINDOW) || (fa == OFF_PCL) || (fa == OFF_STATUS) ||
           (fa == OFF_PTR) || (fa == OFF_PROGRAM_COUNTER_HIGH_LATCH) || (fa == OFF_INTERRUPT_CONTROL);
  endfunction : sfrb_is_dual

  function automatic sfrb_target_t sfrb_decode(input logic [6:0] fa,
                                               input logic [1:0] bank);
    sfrb_target_t t;
    t = '{kind: K_NONE, ram_addr: fa[4:0], port_b: 1'b0};
    if (sfrb_is_dual(fa) || bank == BANK_ZERO) begin
      case (fa)
        OFF_PCL: t.kind = K_PCL;
        OFF_STATUS: t.kind = K_STAT;
        OFF_PTR: t.kind = K_PTR;
        OFF_PROGRAM_COUNTER_HIGH_LATCH: t.kind = K_PROGRAM_COUNTER_HIGH_LATCH;
        OFF_INTERRUPT_CONTROL: t.kind = K_INTERRUPT_CONTROL;
        OFF_PIR: t.kind = K_PIR;
        OFF_TIMER1_CONTROL: t.kind = K_TIMER1_CONTROL;
        OFF_TIMER2_COUNT: t.kind = K_TIMER2_COUNT;
        OFF_TIMER2_CONTROL: t.kind = K_TIMER2_CONTROL;
        OFF_CCPCON: t.kind = K_CCPCON;
        OFF_ADCON: t.kind = K_ADCON;
        OFF_FIRST_PORT_DATA: t.kind = K_FIRST_PORT_DATA;
        OFF_SECOND_PORT_DATA: begin
          t.kind = K_SECOND_PORT_DATA;
          t.port_b = 1'b1;
        end
        OFF_TIMER0_COUNT, OFF_AUX, OFF_T1L, OFF_T1H, OFF_CCPL, OFF_CCPH, OFF_CONVERTER_RESULT: begin
          t.kind = K_RAM;
        end
        default: t.kind = K_NONE;
      endcase
    end else if (bank == BANK_ONE && (fa == OFF_DIRA || fa == OFF_DIRB)) begin
      t.kind = K_DIRAB;
      t.port_b = (fa == OFF_DIRB);
    end
    return t;
  endfunction : sfrb_decode

endpackage : sfrb_pkg
`default_nettype wire

// ---- hw/sfrb_ram.sv ----
`timescale 1ns/10ps
`default_nettype none
module sfrb_ram (
  // Clock
  input wire logic clk_i,
  input wire logic ce_i,
  // Write port
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Read port
  input wire logic [4:0] raddr_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem_q [32];
  logic [7:0] rdata_q;

  // ----------------------------------------
  // Storage cells
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      rdata_q <= mem_q[raddr_i];
    end
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_ram_keeps;
    @(posedge clk_i) (ce_i && we_i) ##1 (ce_i && !we_i && raddr_i == $past(waddr_i))
      |=> rdata_o == $past(wdata_i, 2);
  endproperty
  a_ram_keeps: assert property (p_ram_keeps) else $error("ram lost a byte");

endmodule : sfrb_ram
`default_nettype wire

// ---- hw/sfrb_bank.sv ----
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sfrb_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic power_on_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port pins
  input wire logic [4:0] first_port_pin_i,
  output logic [4:0] first_port_pin_o,
  output logic [4:0] first_port_pin_oe_o,
  input wire logic [7:0] second_port_pin_i,
  output logic [7:0] second_port_pin_o,
  output logic [7:0] second_port_pin_oe_o,
  // Core and peripheral state
  output logic [12:0] pc_o,
  output sfrb_pkg::sfrb_ctrl_t ctrl_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK = 3'b100
  } sfrb_state_t;

  sfrb_state_t st_q;
  logic ack_q;
  logic [31:0] dat_q;
  sfrb_pkg::sfrb_target_t tgt_d;
  sfrb_pkg::sfrb_target_t tgt_q;
  logic [6:0] fa;
  logic [1:0] bank;
  logic req;
  logic wr;
  logic [7:0] wdat;
  logic [7:0] rd_val;
  logic [7:0] ram_rdata;
  logic [7:0] pcl_q;
  logic [4:0] pc_hi_q;
  logic [4:0] program_counter_high_latch_q;
  logic [7:0] status_q;
  logic [7:0] ptr_q;
  logic [7:0] interrupt_control_q;
  logic [7:0] pir_q;
  logic [7:0] timer1_control_q;
  logic [7:0] timer2_count_q;
  logic [7:0] timer2_control_q;
  logic [7:0] ccpcon_q;
  logic [7:0] adcon_q;
  logic [4:0] lat_a_q;
  logic [7:0] lat_b_q;
  logic [4:0] oe_a_q;
  logic [7:0] oe_b_q;
  logic [4:0] meta_a_q;
  logic [4:0] sync_a_q;
  logic [7:0] meta_b_q;
  logic [7:0] sync_b_q;

  // ----------------------------------------
  // Address resolution
  // ----------------------------------------
  assign fa = wb_adr_i[8:2];
  assign bank = status_q[sfrb_pkg::STAT_BANK_HI:sfrb_pkg::STAT_BANK_LO];
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = ce_i && st_q == ST_WAIT && wb_we_i && wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];

  always_comb begin
    if (fa == sfrb_pkg::OFF_WINDOW) begin
      tgt_d = sfrb_pkg::sfrb_decode(ptr_q[6:0],
        {status_q[sfrb_pkg::STAT_IND_BANK], ptr_q[sfrb_pkg::PTR_BANK]});
    end else begin
      tgt_d = sfrb_pkg::sfrb_decode(fa, bank);
    end
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      ack_q <= 1'b0;
      tgt_q <= '{kind: sfrb_pkg::K_NONE, ram_addr: 5'h00, port_b: 1'b0};
    end else if (ce_i) begin
      case (st_q)
        ST_IDLE: begin
          ack_q <= 1'b0;
          if (req) begin
            tgt_q <= tgt_d;
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          ack_q <= 1'b1;
          st_q <= ST_ACK;
        end
        ST_ACK: begin
          ack_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: begin
          ack_q <= 1'b0;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    case (tgt_q.kind)
      sfrb_pkg::K_RAM: rd_val = ram_rdata;
      sfrb_pkg::K_PCL: rd_val = pcl_q;
      sfrb_pkg::K_STAT: rd_val = status_q;
      sfrb_pkg::K_PTR: rd_val = ptr_q;
      sfrb_pkg::K_PROGRAM_COUNTER_HIGH_LATCH: rd_val = {3'h0, program_counter_high_latch_q};
      sfrb_pkg::K_INTERRUPT_CONTROL: rd_val = interrupt_control_q;
      sfrb_pkg::K_PIR: rd_val = pir_q;
      sfrb_pkg::K_TIMER1_CONTROL: rd_val = timer1_control_q;
      sfrb_pkg::K_TIMER2_COUNT: rd_val = timer2_count_q;
      sfrb_pkg::K_TIMER2_CONTROL: rd_val = timer2_control_q;
      sfrb_pkg::K_CCPCON: rd_val = ccpcon_q;
      sfrb_pkg::K_ADCON: rd_val = adcon_q;
      sfrb_pkg::K_FIRST_PORT_DATA: rd_val = {3'h0, sync_a_q};
      sfrb_pkg::K_SECOND_PORT_DATA: rd_val = sync_b_q;
      sfrb_pkg::K_DIRAB: rd_val = tgt_q.port_b ? ~oe_b_q : {3'h0, ~oe_a_q};
      default: rd_val = sfrb_pkg::ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      if (st_q == ST_WAIT && !wb_we_i) begin
        dat_q <= {24'h00_0000, rd_val};
      end else if (st_q == ST_ACK) begin
        dat_q <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------
  // Peripheral byte storage
  // ----------------------------------------
  sfrb_ram u_ram (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(wr && tgt_q.kind == sfrb_pkg::K_RAM),
    .waddr_i(tgt_q.ram_addr),
    .wdata_i(tgt_q.ram_addr == sfrb_pkg::OFF_AUX[4:0] ? (wdat & sfrb_pkg::AUX_MASK) : wdat),
    .raddr_i(tgt_d.ram_addr),
    .rdata_o(ram_rdata)
  );

  // ----------------------------------------
  // Core registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcl_q <= sfrb_pkg::ZERO_BYTE;
      pc_hi_q <= 5'h00;
      program_counter_high_latch_q <= 5'h00;
    end else if (ce_i && wr) begin
      if (tgt_q.kind == sfrb_pkg::K_PCL) begin
        pcl_q <= wdat;
        pc_hi_q <= program_counter_high_latch_q;
      end
      if (tgt_q.kind == sfrb_pkg::K_PROGRAM_COUNTER_HIGH_LATCH) begin
        program_counter_high_latch_q <= wdat[4:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if (power_on_i) begin
        status_q <= sfrb_pkg::STATUS_POR;
        ptr_q <= sfrb_pkg::ZERO_BYTE;
        interrupt_control_q <= sfrb_pkg::ZERO_BYTE;
      end else begin
        status_q <= status_q & sfrb_pkg::STATUS_KEEP;
        interrupt_control_q <= interrupt_control_q & sfrb_pkg::INTERRUPT_CONTROL_KEEP;
      end
    end else if (ce_i && wr) begin
      case (tgt_q.kind)
        sfrb_pkg::K_STAT: begin
          status_q <= (wdat & sfrb_pkg::STATUS_WMASK) | (status_q & ~sfrb_pkg::STATUS_WMASK);
        end
        sfrb_pkg::K_PTR: ptr_q <= wdat;
        sfrb_pkg::K_INTERRUPT_CONTROL: interrupt_control_q <= wdat;
        default: ptr_q <= ptr_q;
      endcase
    end
  end

  // ----------------------------------------
  // Peripheral control registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pir_q <= sfrb_pkg::ZERO_BYTE;
      timer2_count_q <= sfrb_pkg::ZERO_BYTE;
      timer2_control_q <= sfrb_pkg::ZERO_BYTE;
      ccpcon_q <= sfrb_pkg::ZERO_BYTE;
      adcon_q <= sfrb_pkg::ZERO_BYTE;
      if (power_on_i) begin
        timer1_control_q <= sfrb_pkg::ZERO_BYTE;
      end
    end else if (ce_i && wr) begin
      case (tgt_q.kind)
        sfrb_pkg::K_PIR: pir_q <= wdat & sfrb_pkg::PIR_MASK;
        sfrb_pkg::K_TIMER1_CONTROL: timer1_control_q <= wdat & sfrb_pkg::TIMER1_CONTROL_MASK;
        sfrb_pkg::K_TIMER2_COUNT: timer2_count_q <= wdat;
        sfrb_pkg::K_TIMER2_CONTROL: timer2_control_q <= wdat & sfrb_pkg::TIMER2_CONTROL_MASK;
        sfrb_pkg::K_CCPCON: ccpcon_q <= wdat & sfrb_pkg::CCPCON_MASK;
        sfrb_pkg::K_ADCON: adcon_q <= wdat & sfrb_pkg::ADCON_MASK;
        default: timer2_count_q <= timer2_count_q;
      endcase
    end
  end

  // ----------------------------------------
  // Port latches, directions and pins
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_a_q <= 5'h00;
      oe_b_q <= 8'h00;
      if (power_on_i) begin
        lat_a_q <= 5'h00;
        lat_b_q <= sfrb_pkg::ZERO_BYTE;
      end
    end else if (ce_i && wr) begin
      case (tgt_q.kind)
        sfrb_pkg::K_FIRST_PORT_DATA: lat_a_q <= wdat[4:0];
        sfrb_pkg::K_SECOND_PORT_DATA: lat_b_q <= wdat;
        sfrb_pkg::K_DIRAB: begin
          if (tgt_q.port_b) begin
            oe_b_q <= ~wdat;
          end else begin
            oe_a_q <= ~wdat[4:0];
          end
        end
        default: lat_a_q <= lat_a_q;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_a_q <= 5'h00;
      sync_a_q <= 5'h00;
      meta_b_q <= 8'h00;
      sync_b_q <= 8'h00;
    end else if (ce_i) begin
      meta_a_q <= first_port_pin_i;
      sync_a_q <= meta_a_q;
      meta_b_q <= second_port_pin_i;
      sync_b_q <= meta_b_q;
    end
  end

  assign first_port_pin_o = lat_a_q;
  assign first_port_pin_oe_o = oe_a_q;
  assign second_port_pin_o = lat_b_q;
  assign second_port_pin_oe_o = oe_b_q;
  assign pc_o = {pc_hi_q, pcl_q};
  assign ctrl_o = '{interrupt_control: interrupt_control_q, timer1_control: timer1_control_q, timer2_control: timer2_control_q, timer2_count: timer2_count_q,
                    ccpcon: ccpcon_q, adcon: adcon_q};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rd_wait;
    ce_i && st_q == ST_WAIT && !wb_we_i;
  endsequence

  sequence s_rd_done;
    wb_ack_o;
  endsequence

  property p_dual_read;
    @(posedge clk_i) disable iff (rst_i)
      (s_rd_wait and (fa == sfrb_pkg::OFF_PROGRAM_COUNTER_HIGH_LATCH && bank == sfrb_pkg::BANK_ONE))
      |=> s_rd_done ##0 (wb_dat_o == {27'h0, $past(program_counter_high_latch_q)});
  endproperty
  a_dual_read: assert property (p_dual_read) else $error("dual read wrong");

  property p_unmapped_zero;
    @(posedge clk_i) disable iff (rst_i)
      (s_rd_wait and (tgt_q.kind == sfrb_pkg::K_NONE)) |=> s_rd_done ##0 (wb_dat_o == 32'h0);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero");

  property p_pc_transfer;
    @(posedge clk_i) disable iff (rst_i)
      (wr && tgt_q.kind == sfrb_pkg::K_PCL) |=> pc_o[12:8] == $past(program_counter_high_latch_q);
  endproperty
  a_pc_transfer: assert property (p_pc_transfer) else $error("pc high not loaded");

  property p_port_reset;
    @(posedge clk_i) rst_i |=> (first_port_pin_oe_o == 5'h00 && second_port_pin_oe_o == 8'h00);
  endproperty
  a_port_reset: assert property (p_port_reset) else $error("port driving after reset");

  property p_port_pins;
    @(posedge clk_i) disable iff (rst_i)
      (s_rd_wait and (tgt_q.kind == sfrb_pkg::K_SECOND_PORT_DATA))
      |=> s_rd_done ##0 (wb_dat_o[7:0] == $past(sync_b_q));
  endproperty
  a_port_pins: assert property (p_port_pins) else $error("port read not pins");

  property p_por_values;
    @(posedge clk_i) (rst_i && power_on_i)
      |=> (status_q == sfrb_pkg::STATUS_POR && timer1_control_q == 8'h00 && pc_o == 13'h0);
  endproperty
  a_por_values: assert property (p_por_values) else $error("power-on values wrong");

  property p_other_keep;
    @(posedge clk_i) (rst_i && !power_on_i)
      |=> (timer1_control_q == $past(timer1_control_q) && ptr_q == $past(ptr_q) && lat_b_q == $past(lat_b_q));
  endproperty
  a_other_keep: assert property (p_other_keep) else $error("other reset lost value");

  property p_bank_unimpl;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && st_q == ST_IDLE && req && fa == sfrb_pkg::OFF_TIMER2_COUNT && bank[1])
      |=> tgt_q.kind == sfrb_pkg::K_NONE;
  endproperty
  a_bank_unimpl: assert property (p_bank_unimpl) else $error("bank two or three hit");

  property p_window_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr && fa == sfrb_pkg::OFF_WINDOW && tgt_q.kind == sfrb_pkg::K_TIMER2_COUNT)
      |=> timer2_count_q == $past(wdat);
  endproperty
  a_window_write: assert property (p_window_write) else $error("window write lost");

endmodule : sfrb_bank
`default_nettype wire

// ---- tb/sfrb_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sfrb_pin_model (
  // Drive from the bank
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  // Level from the outside world
  input wire logic [7:0] ext_i,
  // Level on the pads
  output logic [7:0] pad_o
);
  // ----------------------------------------
  // Pad resolution
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_o[i] = pin_oe_i[i] ? pin_out_i[i] : ext_i[i];
    end
  end
endmodule : sfrb_pin_model
`default_nettype wire

// ---- tb/sfrb_bank_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module sfrb_bank_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_i;
  logic rst_i;
  logic power_on_i;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [8:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic [7:0] ext_a;
  logic [7:0] ext_b;
  logic [7:0] pad_a;
  logic [7:0] pad_b;
  logic [4:0] pin_a_o;
  logic [4:0] oe_a;
  logic [7:0] pin_b_o;
  logic [7:0] oe_b;
  logic [12:0] pc;
  sfrb_pkg::sfrb_ctrl_t ctrl;
  int n_fail;
  int n_checks;
  int cycles;
  logic [6:0] mask_adr [6];
  logic [7:0] mask_val [6];
  logic [6:0] hole_adr [11];
  logic [6:0] ram_adr [6];

  // ----------------------------------------
  // Design and pad models
  // ----------------------------------------
  sfrb_bank i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .power_on_i(power_on_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .first_port_pin_i(pad_a[4:0]), .first_port_pin_o(pin_a_o),
    .first_port_pin_oe_o(oe_a), .second_port_pin_i(pad_b),
    .second_port_pin_o(pin_b_o), .second_port_pin_oe_o(oe_b), .pc_o(pc), .ctrl_o(ctrl)
  );
  sfrb_pin_model i_pads_a (
    .pin_out_i({3'h0, pin_a_o}), .pin_oe_i({3'h0, oe_a}), .ext_i(ext_a), .pad_o(pad_a)
  );
  sfrb_pin_model i_pads_b (
    .pin_out_i(pin_b_o), .pin_oe_i(oe_b), .ext_i(ext_b), .pad_o(pad_b)
  );

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic wb_xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
                         output logic [7:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_sel <= 4'h1;
    wb_adr <= {a, 2'h0};
    wb_dat_w <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (wb_ack !== 1'b1) begin
      n_fail++;
      $display("mismatch wb_ack expected 1 seen %b", wb_ack);
    end
    q = wb_dat_r[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] ex, input string nm);
    logic [7:0] q;
    wb_xfer(1'b0, a, 8'h00, q);
    `CHK(nm, ex, q)
  endtask : rd

  task automatic do_reset(input logic por);
    @(posedge clk_i);
    rst_i <= 1'b1;
    power_on_i <= por;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask : end_test

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    power_on_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 9'h000;
    wb_sel = 4'h0;
    wb_dat_w = 32'h00000000;
    ext_a = 8'h00;
    ext_b = 8'h00;
    n_fail = 0;
    n_checks = 0;
    cycles = 0;
    mask_adr = '{sfrb_pkg::OFF_PIR, sfrb_pkg::OFF_TIMER1_CONTROL, sfrb_pkg::OFF_TIMER2_CONTROL,
                 sfrb_pkg::OFF_CCPCON, sfrb_pkg::OFF_ADCON, sfrb_pkg::OFF_AUX};
    mask_val = '{sfrb_pkg::PIR_MASK, sfrb_pkg::TIMER1_CONTROL_MASK, sfrb_pkg::TIMER2_CONTROL_MASK,
                 sfrb_pkg::CCPCON_MASK, sfrb_pkg::ADCON_MASK, sfrb_pkg::AUX_MASK};
    hole_adr = '{7'h08, 7'h09, 7'h0D, 7'h13, 7'h14, 7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D};
    ram_adr = '{sfrb_pkg::OFF_TIMER0_COUNT, sfrb_pkg::OFF_T1L, sfrb_pkg::OFF_T1H,
                sfrb_pkg::OFF_CCPL, sfrb_pkg::OFF_CCPH, sfrb_pkg::OFF_CONVERTER_RESULT};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("oe_a", 5'h00, oe_a)
    `CHK("oe_b", 8'h00, oe_b)
    `CHK("pc", 13'h0000, pc)
    rd(sfrb_pkg::OFF_STATUS, sfrb_pkg::STATUS_POR, "status");
    rd(sfrb_pkg::OFF_PTR, 8'h00, "pointer");
    rd(sfrb_pkg::OFF_PROGRAM_COUNTER_HIGH_LATCH, 8'h00, "program_counter_high_latch");
    rd(sfrb_pkg::OFF_WINDOW, 8'h00, "window");
    end_test("reset values");
    for (int i = 0; i < 6; i++) begin
      wr(mask_adr[i], (mask_adr[i] == sfrb_pkg::OFF_AUX) ? 8'h05 : 8'hFF);
      rd(mask_adr[i], mask_val[i], "masked bits");
    end
    for (int i = 0; i < 11; i++) begin
      wr(hole_adr[i], 8'hFF);
      rd(hole_adr[i], 8'h00, "hole");
    end
    for (int i = 0; i < 6; i++) begin
      wr(ram_adr[i], 8'hA0 + 8'(i));
    end
    for (int i = 0; i < 6; i++) begin
      rd(ram_adr[i], 8'hA0 + 8'(i), "ram byte");
    end
    end_test("map");
    wr(sfrb_pkg::OFF_PROGRAM_COUNTER_HIGH_LATCH, 8'hFF);
    rd(sfrb_pkg::OFF_PROGRAM_COUNTER_HIGH_LATCH, 8'h1F, "program_counter_high_latch");
    `CHK("pc_hi", 5'h00, pc[12:8])
    wr(sfrb_pkg::OFF_PCL, 8'h34);
    `CHK("pc", 13'h1F34, pc)
    wr(sfrb_pkg::OFF_PROGRAM_COUNTER_HIGH_LATCH, 8'h0A);
    `CHK("pc", 13'h1F34, pc)
    rd(sfrb_pkg::OFF_PCL, 8'h34, "pcl");
    end_test("program counter");
    ext_a <= 8'h15;
    ext_b <= 8'h3C;
    wr(sfrb_pkg::OFF_SECOND_PORT_DATA, 8'hA5);
    wr(sfrb_pkg::OFF_FIRST_PORT_DATA, 8'h0A);
    rd(sfrb_pkg::OFF_SECOND_PORT_DATA, 8'h3C, "port b pins");
    rd(sfrb_pkg::OFF_FIRST_PORT_DATA, 8'h15, "port a pins");
    `CHK("latch_b", 8'hA5, pin_b_o)
    wr(sfrb_pkg::OFF_INTERRUPT_CONTROL, 8'h81);
    wr(sfrb_pkg::OFF_TIMER1_CONTROL, 8'h15);
    wr(sfrb_pkg::OFF_STATUS, 8'h20);
    rd(sfrb_pkg::OFF_STATUS, 8'h38, "status b1");
    rd(sfrb_pkg::OFF_INTERRUPT_CONTROL, 8'h81, "interrupt_control b1");
    `CHK("ctrl_interrupt_control", 8'h81, ctrl.interrupt_control)
    `CHK("ctrl_timer1_control", 8'h15, ctrl.timer1_control)
    rd(sfrb_pkg::OFF_PROGRAM_COUNTER_HIGH_LATCH, 8'h0A, "program_counter_high_latch b1");
    rd(sfrb_pkg::OFF_TIMER1_CONTROL, 8'h00, "timer1_control b1");
    rd(sfrb_pkg::OFF_DIRB, 8'hFF, "dir b");
    wr(sfrb_pkg::OFF_DIRB, 8'h00);
    wr(sfrb_pkg::OFF_DIRA, 8'h00);
    wr(sfrb_pkg::OFF_STATUS, 8'h00);
    `CHK("oe_b", 8'hFF, oe_b)
    rd(sfrb_pkg::OFF_SECOND_PORT_DATA, 8'hA5, "port b driven");
    rd(sfrb_pkg::OFF_FIRST_PORT_DATA, 8'h0A, "port a driven");
    `CHK("latch_a", 5'h0A, pin_a_o)
    `CHK("oe_a", 5'h1F, oe_a)
    rd(sfrb_pkg::OFF_TIMER1_CONTROL, 8'h15, "timer1_control b0");
    end_test("banks and ports");
    wr(sfrb_pkg::OFF_PTR, 8'h11);
    wr(sfrb_pkg::OFF_WINDOW, 8'h5A);
    rd(sfrb_pkg::OFF_TIMER2_COUNT, 8'h5A, "timer2_count");
    `CHK("timer2_count_out", 8'h5A, ctrl.timer2_count)
    rd(sfrb_pkg::OFF_WINDOW, 8'h5A, "window");
    end_test("indirect");
    wr(sfrb_pkg::OFF_STATUS, 8'h27);
    do_reset(1'b0);
    `CHK("oe_b", 8'h00, oe_b)
    `CHK("oe_a", 5'h00, oe_a)
    `CHK("pc", 13'h0000, pc)
    `CHK("latch_b", 8'hA5, pin_b_o)
    rd(sfrb_pkg::OFF_STATUS, sfrb_pkg::STATUS_KEEP, "status");
    rd(sfrb_pkg::OFF_PTR, 8'h11, "pointer");
    rd(sfrb_pkg::OFF_TIMER1_CONTROL, 8'h15, "timer1_control");
    `CHK("latch_a", 5'h0A, pin_a_o)
    `CHK("ctrl_timer2_control", 8'h00, ctrl.timer2_control)
    `CHK("ctrl_ccpcon", 8'h00, ctrl.ccpcon)
    `CHK("ctrl_adcon", 8'h00, ctrl.adcon)
    rd(sfrb_pkg::OFF_INTERRUPT_CONTROL, sfrb_pkg::INTERRUPT_CONTROL_KEEP, "interrupt_control");
    rd(sfrb_pkg::OFF_TIMER2_COUNT, 8'h00, "timer2_count");
    rd(sfrb_pkg::OFF_TIMER0_COUNT, 8'hA0, "timer0_count");
    rd(sfrb_pkg::OFF_SECOND_PORT_DATA, 8'h3C, "port b pins");
    end_test("other reset");
    do_reset(1'b1);
    `CHK("latch_b", 8'h00, pin_b_o)
    rd(sfrb_pkg::OFF_STATUS, sfrb_pkg::STATUS_POR, "status");
    rd(sfrb_pkg::OFF_PTR, 8'h00, "pointer");
    rd(sfrb_pkg::OFF_TIMER1_CONTROL, 8'h00, "timer1_control");
    rd(sfrb_pkg::OFF_INTERRUPT_CONTROL, 8'h00, "interrupt_control");
    end_test("power-on reset");
    wrap_up();
  end
endmodule : sfrb_bank_tb
`default_nettype wire
